// ==== logic/flr_defines.svh ====
`ifndef FLR_DEFINES_SVH
`define FLR_DEFINES_SVH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define FLR_CMD_CLEAR_FAULTS   8'h03
`define FLR_CMD_OC_LV_THR      8'h48
`define FLR_CMD_OC_WARN_THR    8'h4a
`define FLR_CMD_OT_THR         8'h4f
`define FLR_CMD_OT_ACTION      8'h50

// ----------------------------------------
// Action byte fields
// ----------------------------------------
`define FLR_RESP_MSB           7
`define FLR_RESP_LSB           6
`define FLR_RETRY_MSB          5
`define FLR_RETRY_LSB          3
`define FLR_DLY_MSB            2
`define FLR_DLY_LSB            0
`define FLR_RESP_IGNORE        2'h0
`define FLR_RESP_DELAY         2'h1
`define FLR_RESP_DISABLE       2'h2
`define FLR_RESP_LATCH         2'h3
`define FLR_RETRY_NONE         3'h0
`define FLR_RETRY_FOREVER      3'h7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FLR_OC_LV_THR_RST      16'h0000
`define FLR_OC_WARN_THR_RST    16'h0000
`define FLR_OT_THR_RST         16'h7fff
`define FLR_OT_ACTION_RST      8'h00

// ----------------------------------------
// Link framing
// ----------------------------------------
`define FLR_BYTE_RW            3'h0
`define FLR_BYTE_CMD           3'h1
`define FLR_BYTE_LO            3'h2
`define FLR_BYTE_HI            3'h3
`define FLR_BYTE_LAST          3'h4
`define FLR_BIT_LAST           3'h7

// ----------------------------------------
// Timing
// ----------------------------------------
`define FLR_UNIT_US            1
`define FLR_CLK_MHZ            100

`endif

// ==== logic/flr_pkg.sv ====
package flr_pkg;

    typedef enum logic [1:0] {
        st_run,
        st_delay,
        st_wait,
        st_latch
    } flr_state_t;

endpackage : flr_pkg

// ==== logic/flr_fault_response.sv ====
`timescale 1ns/1ns
`include "flr_defines.svh"

// What this block does
// - Keep over-temperature fault threshold as a 16-bit writable, readable word.
// - Keep over-current warning threshold as a 16-bit writable, readable word.
// - Keep over-current low-voltage fault threshold as a 16-bit writable, readable word.
// - Response 00: ignore the fault, output stays on.
// - Response 01: run on for the delay, then retry path if still hot.
// - Response 10: switch output off at once, then follow retry setting.
// - Response 11: stay off until clear command, reset, or run off-then-on.
// - Retry 000: no restart, stay off until cleared.
// - Retry 1..6: that many restarts, then stay off until cleared.
// - Restart attempts start one spacing apart, two to the power of the delay field, times unit.
// - Retry 111: restart forever until run off, reset, or other fault.
// - Thresholds use word transfers, action uses byte transfers, both ways.
// - Delay field means two to the power of its value in units.
module flr_fault_response #(
    parameter int UNIT_CYCLES = `FLR_UNIT_US * `FLR_CLK_MHZ
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        link_clk,
    input  wire logic        link_frame_n,
    input  wire logic        link_sdi,
    output logic             link_sdo,
    output logic             link_sdo_oe,
    input  wire logic        run_pin,
    input  wire logic [15:0] temp_meas,
    input  wire logic        other_fault,
    output logic             output_enable,
    output logic             fault_flag,
    output logic             fault_latched
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] flr_spacing(input logic [2:0] d);
        flr_spacing = 32'((32'h1 << d) * UNIT_CYCLES);
    endfunction : flr_spacing

    // ----------------------------------------
    // Link domain
    // ----------------------------------------
    logic        lrst_s1;
    logic        lrst_r;
    logic [2:0]  bit_r;
    logic [2:0]  byte_r;
    logic [7:0]  sh_r;
    logic        rw_r;
    logic [7:0]  cmd_r;
    logic [7:0]  lo_r;
    logic [15:0] lv_thr_r;
    logic [15:0] warn_thr_r;
    logic [15:0] ot_thr_r;
    logic [7:0]  act_r;
    logic [15:0] tx_r;
    logic        sdo_r;
    logic        oe_r;
    logic [7:0]  upd_cmd_r;
    logic [15:0] upd_data_r;
    logic        upd_tgl_r;
    logic [7:0]  sh_nxt;
    logic        byte_done;
    logic [7:0]  cmd_now;
    logic [15:0] wr_word;
    logic        wr_go;
    logic [15:0] rd_word;

    function automatic logic is_word(input logic [7:0] c);
        is_word = (c == `FLR_CMD_OC_LV_THR) || (c == `FLR_CMD_OC_WARN_THR)
                  || (c == `FLR_CMD_OT_THR);
    endfunction : is_word

    assign sh_nxt    = {sh_r[6:0], link_sdi};
    assign byte_done = !link_frame_n && (bit_r == `FLR_BIT_LAST);
    assign cmd_now   = (byte_r == `FLR_BYTE_CMD) ? sh_nxt : cmd_r;
    assign wr_word   = {sh_nxt, lo_r};
    // Send byte, write byte and write word each commit on their last byte
    assign wr_go = byte_done && !rw_r && (
                   ((byte_r == `FLR_BYTE_CMD) && (sh_nxt == `FLR_CMD_CLEAR_FAULTS))
                || ((byte_r == `FLR_BYTE_LO) && (cmd_r == `FLR_CMD_OT_ACTION))
                || ((byte_r == `FLR_BYTE_HI) && is_word(cmd_r)));

    always_comb begin
        case (sh_nxt)
            `FLR_CMD_OC_LV_THR:   rd_word = lv_thr_r;
            `FLR_CMD_OC_WARN_THR: rd_word = warn_thr_r;
            `FLR_CMD_OT_THR:      rd_word = ot_thr_r;
            `FLR_CMD_OT_ACTION:   rd_word = {8'h00, act_r};
            default:              rd_word = 16'h0000;
        endcase
    end

    // Reset only seen while the link clock runs; fine, frames need it
    always_ff @(posedge link_clk) begin
        lrst_s1 <= reset;
        lrst_r  <= lrst_s1;
    end

    always_ff @(posedge link_clk) begin
        if (lrst_r || link_frame_n) begin
            bit_r  <= 3'h0;
            byte_r <= `FLR_BYTE_RW;
        end else begin
            bit_r <= bit_r + 3'h1;
            if (bit_r == `FLR_BIT_LAST && byte_r != `FLR_BYTE_LAST) begin
                byte_r <= byte_r + 3'h1;
            end
        end
    end

    always_ff @(posedge link_clk) begin
        if (lrst_r) begin
            sh_r  <= 8'h00;
            rw_r  <= 1'b0;
            cmd_r <= 8'h00;
            lo_r  <= 8'h00;
        end else if (!link_frame_n) begin
            sh_r <= sh_nxt;
            if (byte_done) begin
                case (byte_r)
                    `FLR_BYTE_RW:  rw_r  <= sh_nxt[0];
                    `FLR_BYTE_CMD: cmd_r <= sh_nxt;
                    `FLR_BYTE_LO:  lo_r  <= sh_nxt;
                    default:       lo_r  <= lo_r;
                endcase
            end
        end
    end

    always_ff @(posedge link_clk) begin
        if (lrst_r) begin
            lv_thr_r   <= `FLR_OC_LV_THR_RST;
            warn_thr_r <= `FLR_OC_WARN_THR_RST;
            ot_thr_r   <= `FLR_OT_THR_RST;
            act_r      <= `FLR_OT_ACTION_RST;
        end else if (wr_go) begin
            case (cmd_now)
                `FLR_CMD_OC_LV_THR:   lv_thr_r   <= wr_word;
                `FLR_CMD_OC_WARN_THR: warn_thr_r <= wr_word;
                `FLR_CMD_OT_THR:      ot_thr_r   <= wr_word;
                `FLR_CMD_OT_ACTION:   act_r      <= sh_nxt;
                default:              act_r      <= act_r;
            endcase
        end
    end

    // Held stable after the toggle until the next commit
    always_ff @(posedge link_clk) begin
        if (lrst_r) begin
            upd_cmd_r  <= 8'h00;
            upd_data_r <= 16'h0000;
            upd_tgl_r  <= 1'b0;
        end else if (wr_go) begin
            upd_cmd_r  <= cmd_now;
            upd_data_r <= (byte_r == `FLR_BYTE_HI) ? wr_word : {8'h00, sh_nxt};
            upd_tgl_r  <= ~upd_tgl_r;
        end
    end

    // Read data: low byte first, each byte msb first
    always_ff @(posedge link_clk) begin
        if (lrst_r || link_frame_n) begin
            tx_r  <= 16'h0000;
            sdo_r <= 1'b0;
            oe_r  <= 1'b0;
        end else if (byte_done && byte_r == `FLR_BYTE_CMD && rw_r) begin
            tx_r  <= {rd_word[7:0], rd_word[15:8]};
            sdo_r <= rd_word[7];
            oe_r  <= 1'b1;
        end else if (oe_r) begin
            tx_r  <= {tx_r[14:0], 1'b0};
            sdo_r <= tx_r[14];
        end
    end

    assign link_sdo    = sdo_r;
    assign link_sdo_oe = oe_r;

    // ----------------------------------------
    // Crossing into the core clock
    // ----------------------------------------
    logic        tgl_s1;
    logic        tgl_s2;
    logic        tgl_s3;
    logic        run_s1;
    logic        run_s;
    logic        upd_seen;
    logic        clear_now;
    logic [15:0] ot_thr_m;
    logic [7:0]  act_m;

    always_ff @(posedge clk) begin
        if (reset) begin
            tgl_s1 <= 1'b0;
            tgl_s2 <= 1'b0;
            tgl_s3 <= 1'b0;
            run_s1 <= 1'b0;
            run_s  <= 1'b0;
        end else begin
            tgl_s1 <= upd_tgl_r;
            tgl_s2 <= tgl_s1;
            tgl_s3 <= tgl_s2;
            run_s1 <= run_pin;
            run_s  <= run_s1;
        end
    end

    assign upd_seen  = tgl_s2 ^ tgl_s3;
    assign clear_now = upd_seen && (upd_cmd_r == `FLR_CMD_CLEAR_FAULTS);

    always_ff @(posedge clk) begin
        if (reset) begin
            ot_thr_m <= `FLR_OT_THR_RST;
            act_m    <= `FLR_OT_ACTION_RST;
        end else if (upd_seen) begin
            if (upd_cmd_r == `FLR_CMD_OT_THR) begin
                ot_thr_m <= upd_data_r;
            end
            if (upd_cmd_r == `FLR_CMD_OT_ACTION) begin
                act_m <= upd_data_r[7:0];
            end
        end
    end

    // ----------------------------------------
    // Fault response
    // ----------------------------------------
    flr_pkg::flr_state_t st_r;
    logic        out_en_r;
    logic        flag_r;
    logic        latched_r;
    logic        retry_act_r;
    logic [2:0]  left_r;
    logic [31:0] cnt_r;
    logic        ot_hot;
    logic [1:0]  resp;
    logic [2:0]  retry;
    logic [31:0] gap_m1;

    // Raw compare; both words share one encoding
    assign ot_hot = temp_meas > ot_thr_m;
    assign resp   = act_m[`FLR_RESP_MSB:`FLR_RESP_LSB];
    assign retry  = act_m[`FLR_RETRY_MSB:`FLR_RETRY_LSB];
    assign gap_m1 = flr_spacing(act_m[`FLR_DLY_MSB:`FLR_DLY_LSB]) - 32'h1;

    always_ff @(posedge clk) begin
        if (reset) begin
            st_r        <= flr_pkg::st_run;
            out_en_r    <= 1'b0;
            retry_act_r <= 1'b0;
            left_r      <= 3'h0;
            cnt_r       <= 32'h0;
        end else if (!run_s || clear_now) begin
            st_r        <= flr_pkg::st_run;
            out_en_r    <= run_s;
            retry_act_r <= 1'b0;
            cnt_r       <= 32'h0;
        end else if (other_fault) begin
            st_r     <= flr_pkg::st_latch;
            out_en_r <= 1'b0;
        end else begin
            case (st_r)
                flr_pkg::st_run: begin
                    out_en_r <= 1'b1;
                    if (retry_act_r) begin
                        if (ot_hot && left_r == 3'h0 && retry != `FLR_RETRY_FOREVER) begin
                            st_r     <= flr_pkg::st_latch;
                            out_en_r <= 1'b0;
                        end else if (ot_hot) begin
                            st_r     <= flr_pkg::st_wait;
                            out_en_r <= 1'b0;
                            cnt_r    <= gap_m1;
                        end else if (cnt_r == 32'h0) begin
                            retry_act_r <= 1'b0;
                        end else begin
                            cnt_r <= cnt_r - 32'h1;
                        end
                    end else if (ot_hot) begin
                        case (resp)
                            `FLR_RESP_DELAY: begin
                                st_r  <= flr_pkg::st_delay;
                                cnt_r <= gap_m1;
                            end
                            `FLR_RESP_DISABLE: begin
                                out_en_r    <= 1'b0;
                                st_r        <= (retry == `FLR_RETRY_NONE) ?
                                               flr_pkg::st_latch : flr_pkg::st_wait;
                                cnt_r       <= gap_m1;
                                left_r      <= retry;
                                retry_act_r <= retry != `FLR_RETRY_NONE;
                            end
                            `FLR_RESP_LATCH: begin
                                st_r     <= flr_pkg::st_latch;
                                out_en_r <= 1'b0;
                            end
                            default: out_en_r <= 1'b1;
                        endcase
                    end
                end
                flr_pkg::st_delay: begin
                    out_en_r <= 1'b1;
                    if (cnt_r != 32'h0) begin
                        cnt_r <= cnt_r - 32'h1;
                    end else if (!ot_hot) begin
                        st_r <= flr_pkg::st_run;
                    end else begin
                        out_en_r    <= 1'b0;
                        st_r        <= (retry == `FLR_RETRY_NONE) ?
                                       flr_pkg::st_latch : flr_pkg::st_wait;
                        cnt_r       <= gap_m1;
                        left_r      <= retry;
                        retry_act_r <= retry != `FLR_RETRY_NONE;
                    end
                end
                flr_pkg::st_wait: begin
                    out_en_r <= 1'b0;
                    if (cnt_r != 32'h0) begin
                        cnt_r <= cnt_r - 32'h1;
                    end else begin
                        st_r     <= flr_pkg::st_run;
                        out_en_r <= 1'b1;
                        cnt_r    <= gap_m1;
                        if (retry != `FLR_RETRY_FOREVER) begin
                            left_r <= left_r - 3'h1;
                        end
                    end
                end
                flr_pkg::st_latch: out_en_r <= 1'b0;
                default: st_r <= flr_pkg::st_run;
            endcase
        end
    end

    // Set wins over a clear landing in the same cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            flag_r    <= 1'b0;
            latched_r <= 1'b0;
        end else begin
            flag_r    <= ot_hot ? 1'b1 : (clear_now ? 1'b0 : flag_r);
            latched_r <= st_r == flr_pkg::st_latch;
        end
    end

    assign output_enable = out_en_r;
    assign fault_flag    = flag_r;
    assign fault_latched = latched_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    logic ctl_ok;
    assign ctl_ok = run_s && !clear_now && !other_fault;

    chk_ot_write: assert property (@(posedge link_clk) disable iff (lrst_r)
        (wr_go && cmd_now == `FLR_CMD_OT_THR) |=> ot_thr_r == $past(wr_word))
        else $error("ot threshold not stored");
    chk_read_drive: assert property (@(posedge link_clk) disable iff (lrst_r)
        (byte_done && byte_r == `FLR_BYTE_CMD && rw_r && !link_frame_n)
        |=> link_sdo_oe && link_sdo == $past(rd_word[7]))
        else $error("read data not driven");
    chk_ignore_runs: assert property (@(posedge clk) disable iff (reset)
        (ctl_ok && st_r == flr_pkg::st_run && !retry_act_r && ot_hot
         && resp == `FLR_RESP_IGNORE) |=> out_en_r && st_r == flr_pkg::st_run)
        else $error("ignored fault disturbed output");
    chk_delay_on: assert property (@(posedge clk) disable iff (reset)
        (st_r == flr_pkg::st_delay && $past(st_r == flr_pkg::st_delay)) |-> out_en_r)
        else $error("output dropped during delay");
    chk_disable_now: assert property (@(posedge clk) disable iff (reset)
        (ctl_ok && st_r == flr_pkg::st_run && !retry_act_r && ot_hot
         && resp == `FLR_RESP_DISABLE) |=> !out_en_r)
        else $error("output not disabled at once");
    chk_latch_holds: assert property (@(posedge clk) disable iff (reset)
        (st_r == flr_pkg::st_latch && ctl_ok) |=> st_r == flr_pkg::st_latch && !out_en_r)
        else $error("latched off left without clear");
    chk_no_retry: assert property (@(posedge clk) disable iff (reset)
        (ctl_ok && st_r == flr_pkg::st_run && !retry_act_r && ot_hot
         && resp == `FLR_RESP_DISABLE && retry == `FLR_RETRY_NONE)
        |=> st_r == flr_pkg::st_latch)
        else $error("retried with retry none");
    chk_retry_spent: assert property (@(posedge clk) disable iff (reset)
        (ctl_ok && st_r == flr_pkg::st_run && retry_act_r && ot_hot && left_r == 3'h0
         && retry != `FLR_RETRY_FOREVER) |=> st_r == flr_pkg::st_latch)
        else $error("retries not exhausted to off");
    chk_gap_load: assert property (@(posedge clk) disable iff (reset)
        (st_r == flr_pkg::st_wait && $past(st_r) != flr_pkg::st_wait
         && $stable(act_m)) |-> cnt_r == gap_m1)
        else $error("restart spacing wrong");
    chk_retry_ever: assert property (@(posedge clk) disable iff (reset)
        (ctl_ok && st_r == flr_pkg::st_run && retry_act_r && ot_hot
         && retry == `FLR_RETRY_FOREVER) |=> st_r == flr_pkg::st_wait)
        else $error("continuous retry stopped");
    chk_hot_flag: assert property (@(posedge clk) disable iff (reset)
        ot_hot |=> fault_flag)
        else $error("fault flag missed");

endmodule : flr_fault_response

// ==== test/flr_host_model.sv ====
`timescale 1ns/1ns
`include "flr_defines.svh"

module flr_host_model (
    output logic      link_clk,
    output logic      link_frame_n,
    output logic      link_sdi,
    input  wire logic link_sdo,
    input  wire logic link_sdo_oe
);
    logic oe_ok;

    initial begin
        link_clk     = 1'b0;
        link_frame_n = 1'b1;
        link_sdi     = 1'b0;
        oe_ok        = 1'b1;
    end

    // ----------------------------------------
    // Link clock only runs inside these tasks
    // ----------------------------------------
    task automatic idle(input int n);
        repeat (n) begin
            #15 link_clk = 1'b1;
            #15 link_clk = 1'b0;
        end
    endtask : idle

    // Data changes after the falling edge, held over the rising edge
    task automatic frame(input logic [39:0] bits, input int nbits, output logic [15:0] rd);
        rd = 16'h0000;
        #7 link_frame_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            if (bits[32] && i >= 16) begin
                rd = {rd[14:0], link_sdo};
                if (link_sdo_oe !== 1'b1) oe_ok = 1'b0;
            end
            link_sdi = bits[39-i];
            #15 link_clk = 1'b1;
            #15 link_clk = 1'b0;
        end
        link_frame_n = 1'b1;
        // Released line shows the inverse, not a stale bit
        link_sdi = ~link_sdi;
        idle(1);
        rd = {rd[7:0], rd[15:8]};
    endtask : frame
endmodule : flr_host_model

// ==== test/flr_fault_response_test.sv ====
`timescale 1ns/1ns
`include "flr_defines.svh"

module flr_fault_response_test;
    localparam int UNIT = 2;

    logic        clk;
    logic        reset;
    logic        run_pin;
    logic        other_fault;
    logic [15:0] temp_meas;
    wire logic   link_clk;
    wire logic   link_frame_n;
    wire logic   link_sdi;
    wire logic   link_sdo;
    wire logic   link_sdo_oe;
    wire logic   output_enable;
    wire logic   fault_flag;
    wire logic   fault_latched;
    int          n_mismatch;
    int          n_checks;
    int          rises;
    int          gmin;
    int          gmax;
    int          cyc;
    int          last;
    logic        en_q;
    logic [31:0] seed;
    logic [15:0] v;
    logic [15:0] prev;
    logic [15:0] got;
    logic [2:0]  d;

    flr_fault_response #(.UNIT_CYCLES(UNIT)) dut_u (
        .clk(clk), .reset(reset), .link_clk(link_clk), .link_frame_n(link_frame_n),
        .link_sdi(link_sdi), .link_sdo(link_sdo), .link_sdo_oe(link_sdo_oe),
        .run_pin(run_pin), .temp_meas(temp_meas), .other_fault(other_fault),
        .output_enable(output_enable), .fault_flag(fault_flag),
        .fault_latched(fault_latched)
    );

    flr_host_model host_u (
        .link_clk(link_clk), .link_frame_n(link_frame_n), .link_sdi(link_sdi),
        .link_sdo(link_sdo), .link_sdo_oe(link_sdo_oe)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic int sp(input logic [2:0] dly);
        return UNIT << dly;
    endfunction : sp

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic wr(input logic [7:0] cmd, input logic [15:0] val, input int nbytes);
        host_u.frame({8'h00, cmd, val[7:0], val[15:8], 8'h00}, 16 + 8 * nbytes, got);
        check("oe_after_frame", {15'h0, link_sdo_oe}, 16'h0000);
        step(8);
    endtask : wr

    task automatic rd(input logic [7:0] cmd);
        host_u.frame({8'h01, cmd, 24'h000000}, 32, got);
    endtask : rd

    task automatic clr();
        rises = 0;
        gmin = 9999;
        gmax = 0;
    endtask : clr

    // Restart counter: spacing measured between output rises
    // Sampled mid-cycle, away from the edge that launches the output
    always @(negedge clk) begin
        cyc++;
        if (output_enable === 1'b1 && en_q !== 1'b1) begin
            if (rises > 0 && cyc - last < gmin) gmin = cyc - last;
            if (rises > 0 && cyc - last > gmax) gmax = cyc - last;
            rises++;
            last = cyc;
        end
        en_q = output_enable;
    end

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        #500000;
        n_mismatch++;
        test_done();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        n_mismatch = 0; n_checks = 0; cyc = 0; last = 0; en_q = 1'b0; seed = 32'h0000000b;
        reset = 1'b1; run_pin = 1'b0; other_fault = 1'b0; temp_meas = 16'h0000;
        clr();
        fork
            step(10);
            host_u.idle(4);
        join
        reset = 1'b0;
        host_u.idle(3);
        rd(`FLR_CMD_OC_LV_THR);   check("oclv_rst", got, 16'h0000);
        rd(`FLR_CMD_OC_WARN_THR); check("ocw_rst", got, 16'h0000);
        rd(`FLR_CMD_OT_THR);      check("ot_rst", got, 16'h7fff);
        rd(`FLR_CMD_OT_ACTION);   check("act_rst", got, 16'h0000);
        check("oe_ok", {15'h0, host_u.oe_ok}, 16'h0001);
        for (int k = 0; k < 4; k++) begin
            v = 16'(rnd()); wr(`FLR_CMD_OC_LV_THR, v, 2);
            rd(`FLR_CMD_OC_LV_THR); check("oclv", got, v);
            prev = 16'(rnd()); wr(`FLR_CMD_OC_WARN_THR, prev, 2);
            rd(`FLR_CMD_OC_WARN_THR); check("ocw", got, prev);
            v = 16'(rnd()); wr(`FLR_CMD_OT_THR, v, 2);
            rd(`FLR_CMD_OT_THR); check("ot", got, v);
            v = 16'(rnd()); wr(`FLR_CMD_OT_ACTION, v, 1);
            rd(`FLR_CMD_OT_ACTION); check("act", got, {8'h00, v[7:0]});
        end
        wr(`FLR_CMD_OC_WARN_THR, ~prev, 1);
        rd(`FLR_CMD_OC_WARN_THR); check("ocw_short", got, prev);
        rd(8'h60); check("unmapped", got, 16'h0000);
        // Fault threshold boundary, response ignore
        wr(`FLR_CMD_OT_THR, 16'h1000, 2);
        wr(`FLR_CMD_OT_ACTION, 16'h0000, 1);
        run_pin = 1'b1; temp_meas = 16'h1000; step(6); clr();
        check("flag_eq", {15'h0, fault_flag}, 16'h0000);
        check("on", {15'h0, output_enable}, 16'h0001);
        temp_meas = 16'h1001; step(3);
        check("flag_hot", {15'h0, fault_flag}, 16'h0001);
        step(20);
        check("ign_on", {15'h0, output_enable}, 16'h0001);
        check("ign_rises", rises[15:0], 16'h0000);
        temp_meas = 16'h0800; wr(`FLR_CMD_CLEAR_FAULTS, 16'h0000, 0);
        check("flag_clr", {15'h0, fault_flag}, 16'h0000);
        // Run on for the delay, then no retry
        wr(`FLR_CMD_OT_ACTION, {8'h00, 2'b01, 3'b000, 3'd2}, 1);
        temp_meas = 16'hffff; step(sp(3'd2) - 2);
        check("dly_on", {15'h0, output_enable}, 16'h0001);
        step(6);
        check("dly_off", {15'h0, output_enable}, 16'h0000);
        step(30);
        check("noretry", {15'h0, output_enable}, 16'h0000);
        check("noretry_lat", {15'h0, fault_latched}, 16'h0001);
        temp_meas = 16'h0800; wr(`FLR_CMD_CLEAR_FAULTS, 16'h0000, 0); step(6);
        check("cleared_on", {15'h0, output_enable}, 16'h0001);
        // Disable and retry, each count from 1 to 6
        for (int r = 1; r <= 6; r++) begin
            // Delay field drawn at random each pass, so six of its eight powers of two at most are exercised
            d = 3'(rnd());
            wr(`FLR_CMD_OT_ACTION, {8'h00, 2'b10, 3'(r), d}, 1);
            clr(); temp_meas = 16'h9000; step(2);
            check("dis_off", {15'h0, output_enable}, 16'h0000);
            step(r * (sp(d) + 6) + 30);
            check("retries", rises[15:0], 16'(r));
            check("ret_lat", {15'h0, fault_latched}, 16'h0001);
            if (r > 1) check("gap_lo", {15'h0, gmin >= sp(d)}, 16'h0001);
            if (r > 1) check("gap_hi", {15'h0, gmax <= sp(d) + 4}, 16'h0001);
            temp_meas = 16'h0800; wr(`FLR_CMD_CLEAR_FAULTS, 16'h0000, 0); step(6);
        end
        // Latch off, cleared by run off then on
        wr(`FLR_CMD_OT_ACTION, 16'h00c0, 1);
        temp_meas = 16'h9000; step(3); temp_meas = 16'h0800; step(30);
        check("latch_off", {15'h0, output_enable}, 16'h0000);
        run_pin = 1'b0; step(6); run_pin = 1'b1; step(8);
        check("latch_run", {15'h0, output_enable}, 16'h0001);
        // Endless retry until another fault
        wr(`FLR_CMD_OT_ACTION, {8'h00, 2'b10, 3'b111, 3'd0}, 1);
        clr(); temp_meas = 16'h9000; step(150);
        check("forever", {15'h0, rises >= 8}, 16'h0001);
        other_fault = 1'b1; step(4); clr(); step(30);
        check("other_off", {15'h0, output_enable}, 16'h0000);
        check("other_rises", rises[15:0], 16'h0000);
        check("oe_all", {15'h0, host_u.oe_ok}, 16'h0001);
        test_done();
    end
endmodule : flr_fault_response_test
